// ==== tvp_pkg.sv ====
// Shared constants, bus carrier and helpers of the modulator bank.
package tvp_pkg;

  // ------------------------------------------------------------------
  // Modulator timing
  // ------------------------------------------------------------------
  localparam int unsigned NARROW_DIV   = 16;
  localparam int unsigned NARROW_STEPS = 64;
  localparam int unsigned SLOT_LEN     = 128;
  localparam int unsigned WIDE_BITS    = 14;
  localparam int unsigned SLOT_BITS    = 7;
  localparam logic [5:0]  NARROW_FULL  = 6'h3F;
  localparam logic [13:0] WIDE_CNT_TOP = 14'h3FFF;

  // ------------------------------------------------------------------
  // Register indices, byte address is four times the index
  // ------------------------------------------------------------------
  localparam logic [5:0] IDX_CH1       = 6'h02;
  localparam logic [5:0] IDX_CH11_HIGH = 6'h0C;
  localparam logic [5:0] IDX_CH11_LOW  = 6'h0D;
  localparam logic [5:0] IDX_CH6_HIGH  = 6'h0E;
  localparam logic [5:0] IDX_CH6_LOW   = 6'h0F;
  localparam logic [5:0] IDX_PORT4_SEL = 6'h10;
  localparam logic [5:0] IDX_PORT5_SEL = 6'h11;
  localparam logic [5:0] IDX_STATUS    = 6'h12;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int unsigned NUM_NARROW    = 10;
  localparam int unsigned NUM_SHARED    = 5;
  localparam int unsigned P4_SEL_LSB    = 2;
  localparam int unsigned CH6_WIDE_BIT  = 7;
  localparam logic [3:0]  P4_SEL_RESET  = 4'hF;
  localparam logic        P5_SEL_RESET  = 1'b1;
  localparam logic [7:0]  P4_RSVD_ONES  = 8'hC3;
  localparam logic [5:0]  VAL_RESET     = 6'h00;
  localparam logic [6:0]  RATIO_RESET   = 7'h00;

  // ------------------------------------------------------------------
  // Bus carrier
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        read;
    logic        write;
    logic [7:0]  address;
    logic [3:0]  byteenable;
    logic [31:0] writedata;
  } tvp_av_req_s;

  // Reverses a slot number so extra pulses spread over the cycle.
  function automatic logic [6:0] bitrev7(input logic [6:0] v);
    logic [6:0] r;
    for (int i = 0; i < 7; i++)
    begin
      r[i] = v[6-i];
    end
    return r;
  endfunction

endpackage

// ==== tvp_modulator_ch6.sv ====
// Six-bit modulator channel comparing a shared step against its value.
`timescale 1ns/100ps
module tvp_modulator_ch6 (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic [5:0] step,
  input  wire logic [5:0] value,
  output logic            out_q
);

  typedef struct packed {
    logic out;
  } tvp_p6_s;

  tvp_p6_s q;
  tvp_p6_s d;

  always_comb
  begin
    d = q;
    d.out = (value == tvp_pkg::NARROW_FULL) | (step < value); // R14 R15
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign out_q = q.out;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_zero_low: assert property (value == 6'h00 |=> !out_q) // R14
    else $error("zero value did not give a low output");
  a_full_high: assert property (value == 6'h3F |=> out_q) // R15
    else $error("full value did not give a high output");

endmodule

// ==== tvp_pwm14.sv ====
// Fourteen-bit distributed-pulse modulator channel.
`timescale 1ns/100ps
module tvp_pwm14 (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        enable,
  input  wire logic [13:0] cnt,
  input  wire logic [6:0]  ratio_high,
  input  wire logic [6:0]  ratio_low,
  output logic             out_q
);

  typedef struct packed {
    logic out;
  } tvp_p14_s;

  tvp_p14_s   q;
  tvp_p14_s   d;
  logic [6:0] slot_up;
  logic [6:0] pos;
  logic       extra;
  logic [7:0] width;

  always_comb
  begin
    d       = q;
    slot_up = ~cnt[13:7]; // R9
    pos     = ~cnt[6:0];
    extra   = tvp_pkg::bitrev7(slot_up) < ratio_low; // R8
    width   = {1'b0, ratio_high} + {7'h00, extra}; // R7 R10
    d.out   = enable & ({1'b0, pos} < width);
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
      q <= '0;
    else
      q <= d;
  end

  assign out_q = q.out;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  a_slot_head: assert property
    (enable && cnt[6:0] == 7'h7F && ratio_high != 7'h00 |=> out_q) // R7
    else $error("slot did not open with a high level");
  a_slot_tail: assert property
    (enable && cnt[6:0] == 7'h00 && ratio_high != 7'h7F |=> !out_q) // R10
    else $error("last step of a slot was high without full width");

endmodule

// ==== tvp_pwm_bank.sv ====
// Modulator bank with pin routing and an Avalon-MM register slave.
//
// Contract
// R1 - Port-4 select bits 5, 4, 3, 2 steer the pins of channels 10, 9, 8, 7.
// R2 - A select bit at 0 gives the pin to the modulator, at 1 to the port.
// R3 - After reset the port-4 select bits 5 to 2 read 1, the port function.
// R4 - Port-5 select bit 0 gives channel 1 at 0 and port pin 0 at 1, reset 1.
// R5 - Channel 6 runs as six-bit or fourteen-bit as its bit 7 control says.
// R6 - A fourteen-bit ratio is held in a high and a low register.
// R7 - The upper seven ratio bits set the basic pulse width in every slot.
// R8 - The lower seven ratio bits set how many slots get an extra step.
// R9 - A fourteen-bit down counter gives 128 slots numbered 7Fh down to 0.
// R10 - Upper-bit width wins, so a full width fills every one of 128 slots; the code fills at most 127 slots and leaves one at 127 steps.
// R11 - The distribution pulse rate is the crystal clock over 128.
// R12 - Each slot recurs at the crystal clock over 128.
// R13 - A full fourteen-bit cycle lasts 16384 crystal clock periods.
// R14 - A six-bit channel at zero holds its output low.
// R15 - A six-bit channel at 3Fh holds its output high.
// R16 - The six-bit period is 64 steps of the crystal clock over 16.
`timescale 1ns/100ps
module tvp_pwm_bank #(
  parameter int unsigned NARROW_DIV = tvp_pkg::NARROW_DIV
) (
  input  wire logic                mclk,
  input  wire logic                reset,
  input  wire tvp_pkg::tvp_av_req_s av_req,
  output logic [31:0]              av_readdata,
  output logic                     av_waitrequest,
  output logic [10:0]              modulator_out,
  input  wire logic [4:0]          pin_in,
  output logic [4:0]               pin_out,
  output logic [4:0]               pin_oe_n,
  input  wire logic [4:0]          port_dout,
  input  wire logic [4:0]          port_drive,
  output logic [4:0]               port_din
);

  // ------------------------------------------------------------------
  // Parameter check
  // ------------------------------------------------------------------
  if (NARROW_DIV < 2 || NARROW_DIV > 16)
  begin : g_bad_div
    $error("NARROW_DIV must lie between 2 and 16");
  end

  localparam logic [3:0] DIV_LAST = 4'(NARROW_DIV - 1);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [9:0][5:0] val;
    logic [6:0]      c11h;
    logic [6:0]      c11l;
    logic [6:0]      c6h;
    logic [6:0]      c6l;
    logic            c6_wide;
    logic [3:0]      p4sel;
    logic            p5sel;
    logic            wait_q;
    logic [31:0]     rdata;
    logic [3:0]      div;
    logic            tick;
    logic [5:0]      step;
    logic [13:0]     cnt;
    logic [10:0]     mod;
    logic [4:0]      sync1;
    logic [4:0]      sync2;
    logic [4:0]      pout;
    logic [4:0]      poe_n;
  } tvp_bank_s;

  tvp_bank_s   q;
  tvp_bank_s   d;
  logic [5:0]  idx;
  logic [7:0]  wd;
  logic [7:0]  rd;
  logic        wr_go;
  logic [4:0]  sel;
  logic [4:0]  shared_mod;
  logic [9:0]  narrow_out;
  logic        ch6_wide_out;
  logic        ch11_out;

  assign idx   = av_req.address[7:2];
  assign wd    = av_req.writedata[7:0];
  assign wr_go = av_req.write && av_req.byteenable[0] && !q.wait_q;

  // ------------------------------------------------------------------
  // Channels
  // ------------------------------------------------------------------
  for (genvar g = 0; g < tvp_pkg::NUM_NARROW; g++)
  begin : g_narrow
    tvp_modulator_ch6 u_modulator_ch6 (
      .mclk  (mclk),
      .reset (reset),
      .step  (q.step),
      .value (q.val[g]),
      .out_q (narrow_out[g])
    );
  end

  tvp_pwm14 u_ch6_wide (
    .mclk       (mclk),
    .reset      (reset),
    .enable     (q.c6_wide),
    .cnt        (q.cnt),
    .ratio_high (q.c6h),
    .ratio_low  (q.c6l),
    .out_q      (ch6_wide_out)
  );

  tvp_pwm14 u_ch11 (
    .mclk       (mclk),
    .reset      (reset),
    .enable     (1'b1),
    .cnt        (q.cnt),
    .ratio_high (q.c11h),
    .ratio_low  (q.c11l),
    .out_q      (ch11_out)
  );

  // ------------------------------------------------------------------
  // Register read decode
  // ------------------------------------------------------------------
  always_comb
  begin
    rd = 8'h00;
    if (idx >= tvp_pkg::IDX_CH1 && idx < tvp_pkg::IDX_CH11_HIGH)
      rd = {2'b00, q.val[4'(idx - tvp_pkg::IDX_CH1)]};
    else
    begin
      unique case (idx)
        tvp_pkg::IDX_CH11_HIGH: rd = {1'b0, q.c11h}; // R6
        tvp_pkg::IDX_CH11_LOW:  rd = {1'b0, q.c11l};
        tvp_pkg::IDX_CH6_HIGH:  rd = {q.c6_wide, q.c6h}; // R5
        tvp_pkg::IDX_CH6_LOW:   rd = {1'b0, q.c6l};
        tvp_pkg::IDX_PORT4_SEL:
          rd = tvp_pkg::P4_RSVD_ONES | {2'b00, q.p4sel, 2'b00};
        tvp_pkg::IDX_PORT5_SEL: rd = {7'h00, q.p5sel};
        tvp_pkg::IDX_STATUS:    rd = {1'b0, q.cnt[13:7]}; // R9
        default:                rd = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb
  begin
    d       = q;
    d.sync1 = pin_in;
    d.sync2 = q.sync1;

    d.tick = 1'b0;
    if (q.div == DIV_LAST)
    begin
      d.div  = 4'h0;
      d.tick = 1'b1; // R16
    end
    else
      d.div = q.div + 4'h1;
    if (q.tick)
      d.step = q.step + 6'h01; // R16
    d.cnt = q.cnt - 14'h0001; // R9 R11 R12 R13

    if ((av_req.read || av_req.write) && q.wait_q)
    begin
      d.wait_q = 1'b0;
      if (av_req.read)
        d.rdata = {24'h00_0000, rd};
    end
    else
      d.wait_q = 1'b1;

    if (wr_go)
    begin
      for (int i = 0; i < tvp_pkg::NUM_NARROW; i++)
      begin
        if (idx == 6'(tvp_pkg::IDX_CH1 + 6'(i)))
          d.val[i] = wd[5:0];
      end
      unique case (idx)
        tvp_pkg::IDX_CH11_HIGH: d.c11h = wd[6:0]; // R6
        tvp_pkg::IDX_CH11_LOW:  d.c11l = wd[6:0];
        tvp_pkg::IDX_CH6_HIGH:
        begin
          d.c6h     = wd[6:0]; // R6
          d.c6_wide = wd[tvp_pkg::CH6_WIDE_BIT]; // R5
        end
        tvp_pkg::IDX_CH6_LOW:   d.c6l = wd[6:0];
        tvp_pkg::IDX_PORT4_SEL:
          d.p4sel = wd[tvp_pkg::P4_SEL_LSB +: 4]; // R1
        tvp_pkg::IDX_PORT5_SEL: d.p5sel = wd[0]; // R4
        default:                d.p5sel = q.p5sel;
      endcase
    end

    d.mod    = {ch11_out, narrow_out};
    d.mod[5] = q.c6_wide ? ch6_wide_out : narrow_out[5]; // R5

    for (int i = 0; i < tvp_pkg::NUM_SHARED; i++)
    begin
      d.pout[i]  = sel[i] ? port_dout[i] : shared_mod[i]; // R2
      d.poe_n[i] = sel[i] ? ~port_drive[i] : 1'b0; // R2
    end
  end

  // ------------------------------------------------------------------
  // Pin order: port 5 pin 0, then port 4 pins 4 to 7
  // ------------------------------------------------------------------
  assign sel        = {q.p4sel, q.p5sel}; // R1 R4
  assign shared_mod = {q.mod[9], q.mod[8], q.mod[7], q.mod[6], q.mod[0]};

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      q         <= '0;
      q.val     <= {tvp_pkg::NUM_NARROW{tvp_pkg::VAL_RESET}};
      q.c11h    <= tvp_pkg::RATIO_RESET;
      q.c11l    <= tvp_pkg::RATIO_RESET;
      q.c6h     <= tvp_pkg::RATIO_RESET;
      q.c6l     <= tvp_pkg::RATIO_RESET;
      q.p4sel   <= tvp_pkg::P4_SEL_RESET; // R3
      q.p5sel   <= tvp_pkg::P5_SEL_RESET; // R4
      q.wait_q  <= 1'b1;
      q.cnt     <= tvp_pkg::WIDE_CNT_TOP;
      q.poe_n   <= 5'h1F;
    end
    else
      q <= d;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  assign av_readdata    = q.rdata;
  assign av_waitrequest = q.wait_q;
  assign modulator_out  = q.mod;
  assign pin_out        = q.pout;
  assign pin_oe_n       = q.poe_n;
  assign port_din       = q.sync2;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  logic [15:0] gap_q;

  always_ff @(posedge mclk)
  begin
    if (reset)
      gap_q <= 16'h0000;
    else if (q.tick && q.step == 6'h3F)
      gap_q <= 16'h0001;
    else
      gap_q <= gap_q + 16'h0001;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence s_req_start;
    (av_req.read || av_req.write) && av_waitrequest;
  endsequence

  sequence s_answer;
    !av_waitrequest ##1 av_waitrequest;
  endsequence

  a_bus_answer: assert property (s_req_start |=> s_answer)
    else $error("bus request not answered after one wait cycle");

  a_reset_sel: assert property
    ($past(reset) |-> q.p4sel == 4'hF && q.p5sel) // R3
    else $error("select bits not at port function after reset");

  a_route_ch7: assert property
    (!q.p4sel[0] |=> pin_out[1] == $past(q.mod[6]) && !pin_oe_n[1]) // R1
    else $error("channel 7 not routed to its pin");

  a_route_port: assert property
    (q.p4sel[3] |=> pin_out[4] == $past(port_dout[4])) // R2
    else $error("port function not routed to pin 7");

  a_route_ch1: assert property
    (!q.p5sel |=> pin_out[0] == $past(q.mod[0]) && !pin_oe_n[0]) // R4
    else $error("channel 1 not routed to its pin");

  a_ch6_mode: assert property
    (q.c6_wide |=> modulator_out[5] == $past(ch6_wide_out)) // R5
    else $error("channel 6 wide mode not selected");

  a_slot_period: assert property
    (q.cnt[6:0] == 7'h00 |-> ##128 q.cnt[6:0] == 7'h00) // R12
    else $error("slot period is not 128 clocks");

  a_wide_wrap: assert property
    (q.cnt == 14'h0000 |=> q.cnt == 14'h3FFF) // R13
    else $error("wide counter did not wrap to its top");

  a_narrow_period: assert property
    (q.tick && q.step == 6'h3F |-> gap_q == 16'(NARROW_DIV * 64)) // R16
    else $error("six-bit period is not 64 divided steps");

  sequence s_write_taken;
    av_req.write && av_req.byteenable[0] && !av_waitrequest;
  endsequence

  a_ratio_write: assert property // R6
    (s_write_taken ##0 idx == tvp_pkg::IDX_CH11_HIGH
      |=> q.c11h == $past(wd[6:0]))
    else $error("ratio write did not land");

  a_sel_write: assert property // R1
    (s_write_taken ##0 idx == tvp_pkg::IDX_PORT4_SEL
      |=> q.p4sel == $past(wd[5:2]))
    else $error("port-4 select write did not land");

  a_mode_write: assert property // R5
    (s_write_taken ##0 idx == tvp_pkg::IDX_CH6_HIGH
      |=> q.c6_wide == $past(wd[7]))
    else $error("channel 6 mode bit write did not land");

  a_port5_write: assert property // R4
    (s_write_taken ##0 idx == tvp_pkg::IDX_PORT5_SEL
      |=> q.p5sel == $past(wd[0]))
    else $error("port-5 select write did not land");

  a_route_oe: assert property // R2
    (q.p4sel[3] |=> pin_oe_n[4] == !$past(port_drive[4]))
    else $error("port direction not routed to pin 7");

  a_slot_count: assert property // R9
    (q.cnt[6:0] == 7'h00 |=> q.cnt[13:7] == $past(q.cnt[13:7]) - 7'h01)
    else $error("slot number did not count down by one");

  a_cnt_step: assert property // R9
    (q.cnt != 14'h0000 |=> q.cnt == $past(q.cnt) - 14'h0001)
    else $error("wide counter did not count down by one");

  a_tick_single: assert property // R16
    (q.tick |=> !q.tick)
    else $error("divider pulse lasted more than one cycle");

  a_reset_pins: assert property // R3
    ($past(reset) |-> pin_oe_n == 5'h1F && pin_out == 5'h00)
    else $error("pins not released after reset");

endmodule

// ==== test_tv_pwm_bank_pin_select.sv ====
// Self-checking testbench of the modulator bank and pin routing.
`timescale 1ns/100ps
module test_tv_pwm_bank_pin_select;
  localparam int unsigned ND = 2;
  logic                 mclk;
  logic                 reset;
  tvp_pkg::tvp_av_req_s av_req;
  logic [31:0]          av_readdata;
  logic                 av_waitrequest;
  logic [10:0]          modulator_out;
  logic [4:0]           pin_in;
  logic [4:0]           pin_out;
  logic [4:0]           pin_oe_n;
  logic [4:0]           port_dout;
  logic [4:0]           port_drive;
  logic [4:0]           port_din;
  int                   n_mismatch;
  int                   checks_done;

  tvp_pwm_bank #(.NARROW_DIV(ND)) i_tvp_pwm_bank (
    .mclk           (mclk),
    .reset          (reset),
    .av_req         (av_req),
    .av_readdata    (av_readdata),
    .av_waitrequest (av_waitrequest),
    .modulator_out  (modulator_out),
    .pin_in         (pin_in),
    .pin_out        (pin_out),
    .pin_oe_n       (pin_oe_n),
    .port_dout      (port_dout),
    .port_drive     (port_drive),
    .port_din       (port_din)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    int n;
    @(posedge mclk);
    av_req.read       <= !wr;
    av_req.write      <= wr;
    av_req.byteenable <= 4'h1;
    av_req.address    <= {idx, 2'b00};
    av_req.writedata  <= {24'h00_0000, wd};
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (av_waitrequest !== 1'b0);
    check(32'(n), 32'h0000_0002);
    rd = av_readdata;
    av_req.read  <= 1'b0;
    av_req.write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    bus(1'b0, idx, 8'h00, rd);
    check(rd, exp);
  endtask

  task automatic count_high(input int n, input int b, output int c);
    c = 0;
    repeat (4) @(posedge mclk);
    repeat (n)
    begin
      @(posedge mclk);
      if (modulator_out[b] === 1'b1)
        c++;
    end
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    rdchk(tvp_pkg::IDX_PORT4_SEL, 32'h0000_00FF);
    rdchk(tvp_pkg::IDX_PORT5_SEL, 32'h0000_0001);
    check({27'h000_0000, pin_oe_n}, 32'h0000_001F);
    rdchk(6'h3F, 32'h0000_0000);
    wr(tvp_pkg::IDX_PORT4_SEL, 8'h00);
    rdchk(tvp_pkg::IDX_PORT4_SEL, 32'h0000_00C3);
  endtask

  task automatic t_pins();
    wr(tvp_pkg::IDX_CH1, 8'h3F);
    for (int i = 6; i < 10; i++)
      wr(tvp_pkg::IDX_CH1 + 6'(i), 8'h3F);
    wr(tvp_pkg::IDX_PORT5_SEL, 8'h00);
    repeat (6) @(posedge mclk);
    check({27'h000_0000, pin_out}, 32'h0000_001F);
    check({27'h000_0000, pin_oe_n}, 32'h0000_0000);
    port_drive <= 5'h10;
    port_dout  <= 5'h00;
    wr(tvp_pkg::IDX_PORT4_SEL, 8'h20);
    repeat (6) @(posedge mclk);
    check({27'h000_0000, pin_out}, 32'h0000_000F);
    check({27'h000_0000, pin_oe_n}, 32'h0000_0000);
    wr(tvp_pkg::IDX_PORT5_SEL, 8'h01);
    repeat (6) @(posedge mclk);
    check({27'h000_0000, pin_oe_n}, 32'h0000_0001);
    pin_in <= 5'h0A;
    repeat (4) @(posedge mclk);
    check({27'h000_0000, port_din}, 32'h0000_000A);
  endtask

  task automatic t_narrow();
    int c;
    wr(tvp_pkg::IDX_CH1 + 6'h01, 8'h00);
    wr(tvp_pkg::IDX_CH1 + 6'h02, 8'h3F);
    wr(tvp_pkg::IDX_CH1 + 6'h03, 8'h20);
    count_high(64 * ND, 1, c);
    check(32'(c), 32'h0000_0000);
    count_high(64 * ND, 2, c);
    check(32'(c), 32'(64 * ND));
    count_high(64 * ND, 3, c);
    check(32'(c), 32'(32 * ND));
  endtask

  task automatic t_wide();
    int c;
    wr(tvp_pkg::IDX_CH11_HIGH, 8'h10);
    wr(tvp_pkg::IDX_CH11_LOW, 8'h05);
    count_high(16384, 10, c);
    check(32'(c), 32'(16 * 128 + 5));
    wr(tvp_pkg::IDX_CH11_HIGH, 8'h7F);
    wr(tvp_pkg::IDX_CH11_LOW, 8'h7F);
    count_high(16384, 10, c);
    check(32'(c), 32'(127 * 128 + 127));
    wr(tvp_pkg::IDX_CH6_HIGH, 8'hC0);
    wr(tvp_pkg::IDX_CH6_LOW, 8'h00);
    count_high(16384, 5, c);
    check(32'(c), 32'(64 * 128));
    wr(tvp_pkg::IDX_CH6_HIGH, 8'h40);
    wr(tvp_pkg::IDX_CH1 + 6'h05, 8'h3F);
    count_high(128, 5, c);
    check(32'(c), 32'h0000_0080);
  endtask

  task automatic t_slot();
    logic [31:0] s0;
    logic [31:0] s1;
    bus(1'b0, tvp_pkg::IDX_STATUS, 8'h00, s0);
    repeat (125) @(posedge mclk);
    bus(1'b0, tvp_pkg::IDX_STATUS, 8'h00, s1);
    check(s1, {25'h000_0000, 7'(s0[6:0] - 7'h01)});
  endtask

  // ------------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ------------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  initial
  begin
    n_mismatch  = 0;
    checks_done = 0;
    reset       = 1'b1;
    av_req      = '0;
    pin_in      = 5'h00;
    port_dout   = 5'h00;
    port_drive  = 5'h00;
    repeat (10) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_pins();
    t_narrow();
    t_slot();
    t_wide();
    print_verdict();
  end

  initial
  begin
    #(40 * 90000);
    n_mismatch++;
    print_verdict();
  end
endmodule
